/* sba_serial_byte_access.sv */
// Serial bus byte access engine: host registers and transaction sequencer.
// Assumes a byte-wide register port on clk; bus pins are open drain.
`include "sba_params.svh"
`timescale 1ns/10ps
`default_nettype none
module sba_serial_byte_access #(
  parameter int CLK_MHZ      = `SBA_CLK_MHZ,
  parameter int SCL_KHZ      = `SBA_SCL_KHZ,
  parameter int SCL_TEST_KHZ = `SBA_SCL_TEST_KHZ
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic [7:0]      regRdata,
  // Two-wire bus, enable low pulls the wire low
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sclOutEn,
  output logic            sdaOutEn
);
  // Quarter-bit divider terms
  localparam int QDIV_NORM = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  localparam int QDIV_TEST = (CLK_MHZ * 1000) / (SCL_TEST_KHZ * 4);
  // Refuse dividers the bit engine cannot run with
  if (QDIV_NORM < 2 || QDIV_NORM > 65535 || QDIV_TEST < 2 || QDIV_TEST > QDIV_NORM) begin : g_bad_div
    $error("sba_serial_byte_access: unusable serial clock divider");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [7:0]  xferByte, next_xferByte;
  logic [7:0]  targetByteOffset, next_targetByteOffset;
  logic [7:0]  targetAddr, next_targetAddr;
  logic        shortProtocolSelect, next_shortProtocolSelect;
  logic        fastClockTest, next_fastClockTest;
  logic        requestError, next_requestError;
  logic        requestInProgress;
  logic [15:0] divCnt, next_divCnt;
  logic        tick;
  sba_pkg::sba_txn_t txn, next_txn;
  logic        cmdValid, next_cmdValid;
  sba_pkg::sba_cmd_t cmd, next_cmd;
  logic [7:0]  txByte, next_txByte;
  logic        ackOut, next_ackOut;
  logic        cmdDone, nackSeen;
  logic [7:0]  rxByte;
  logic        launch;

  assign launch            = regWrite && hit(regAddr, `SBA_OFF_TARGET) && !requestInProgress;
  assign requestInProgress = (txn != sba_pkg::SBA_T_IDLE);
  assign tick              = (divCnt == 16'h0000);

  // Serial clock divider
  always_comb begin
    if (tick) begin
      next_divCnt = fastClockTest ? 16'(QDIV_TEST - 1) : 16'(QDIV_NORM - 1);
    end else begin
      next_divCnt = divCnt - 16'h0001;
    end
  end

  // Register file
  always_comb begin
    next_xferByte            = xferByte;
    next_targetByteOffset    = targetByteOffset;
    next_targetAddr          = targetAddr;
    next_shortProtocolSelect = shortProtocolSelect;
    next_fastClockTest       = fastClockTest;
    next_requestError        = requestError;
    if (regWrite && !requestInProgress) begin
      if (hit(regAddr, `SBA_OFF_DATA))   next_xferByte = regWdata;
      if (hit(regAddr, `SBA_OFF_INDEX))  next_targetByteOffset = regWdata;
      if (hit(regAddr, `SBA_OFF_TARGET)) next_targetAddr = regWdata;
    end
    if (regWrite && hit(regAddr, `SBA_OFF_CTRL)) begin
      next_shortProtocolSelect = regWdata[`SBA_BIT_PROT];
      next_fastClockTest       = regWdata[`SBA_BIT_TEST];
      if (regWdata[`SBA_BIT_ERR]) next_requestError = 1'b0;
    end
    // Received byte replaces the data register; set wins over clear
    if (txn == sba_pkg::SBA_T_DATA && cmdDone && targetAddr[0]) begin
      next_xferByte = rxByte;
    end
    if (cmdDone && nackSeen && (txn == sba_pkg::SBA_T_ADDR || txn == sba_pkg::SBA_T_INDEX ||
        txn == sba_pkg::SBA_T_RADDR || (txn == sba_pkg::SBA_T_DATA && !targetAddr[0]))) begin
      next_requestError = 1'b1;
    end
  end

  // Transaction sequencer
  always_comb begin
    next_txn      = txn;
    next_cmdValid = 1'b0;
    next_cmd      = cmd;
    next_txByte   = txByte;
    next_ackOut   = 1'b1;
    case (txn)
      sba_pkg::SBA_T_IDLE: if (launch) begin
        next_txn      = sba_pkg::SBA_T_ADDR;
        next_cmdValid = 1'b1;
        next_cmd      = sba_pkg::SBA_CMD_START;
      end
      sba_pkg::SBA_T_ADDR: if (cmdDone) begin
        if (cmd == sba_pkg::SBA_CMD_START) begin
          next_cmdValid = 1'b1;
          next_cmd      = sba_pkg::SBA_CMD_BYTE;
          // Short protocol sends the real direction at once
          next_txByte   = {targetAddr[7:1], shortProtocolSelect & targetAddr[0]};
        end else if (nackSeen) begin
          next_txn = sba_pkg::SBA_T_STOP;
        end else if (shortProtocolSelect) begin
          next_txn = sba_pkg::SBA_T_DATA;
        end else begin
          next_txn      = sba_pkg::SBA_T_INDEX;
          next_cmdValid = 1'b1;
          next_txByte   = targetByteOffset;
        end
        if (next_txn == sba_pkg::SBA_T_DATA) begin
          next_cmdValid = 1'b1;
          // Receive releases the wire for the data bits and ends with no-ack
          next_txByte   = targetAddr[0] ? 8'hFF : xferByte;
          next_ackOut   = 1'b1;
        end
      end
      sba_pkg::SBA_T_INDEX: if (cmdDone) begin
        next_cmdValid = 1'b1;
        if (nackSeen) begin
          next_txn = sba_pkg::SBA_T_STOP;
          next_cmdValid = 1'b0;
        end else if (targetAddr[0]) begin
          next_txn = sba_pkg::SBA_T_RSTA;
          next_cmd = sba_pkg::SBA_CMD_START;
        end else begin
          next_txn    = sba_pkg::SBA_T_DATA;
          next_txByte = xferByte;
        end
      end
      sba_pkg::SBA_T_RSTA: if (cmdDone) begin
        next_txn      = sba_pkg::SBA_T_RADDR;
        next_cmdValid = 1'b1;
        next_cmd      = sba_pkg::SBA_CMD_BYTE;
        next_txByte   = {targetAddr[7:1], 1'b1};
      end
      sba_pkg::SBA_T_RADDR: if (cmdDone) begin
        if (nackSeen) begin
          next_txn = sba_pkg::SBA_T_STOP;
        end else begin
          next_txn      = sba_pkg::SBA_T_DATA;
          next_cmdValid = 1'b1;
          next_txByte   = 8'hFF;
          next_ackOut   = 1'b1;
        end
      end
      sba_pkg::SBA_T_DATA: if (cmdDone) begin
        next_txn = sba_pkg::SBA_T_STOP;
      end
      sba_pkg::SBA_T_STOP: begin
        next_txn      = sba_pkg::SBA_T_DONE;
        next_cmdValid = 1'b1;
        next_cmd      = sba_pkg::SBA_CMD_STOP;
      end
      sba_pkg::SBA_T_DONE: if (cmdDone) begin
        next_txn = sba_pkg::SBA_T_IDLE;
      end
      default: next_txn = sba_pkg::SBA_T_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xferByte            <= `SBA_RST_BYTE;
      targetByteOffset    <= `SBA_RST_BYTE;
      targetAddr          <= `SBA_RST_BYTE;
      shortProtocolSelect <= 1'b0;
      fastClockTest       <= 1'b0;
      requestError        <= 1'b0;
      divCnt              <= 16'h0000;
      txn                 <= sba_pkg::SBA_T_IDLE;
      cmdValid            <= 1'b0;
      cmd                 <= sba_pkg::SBA_CMD_START;
      txByte              <= 8'hFF;
      ackOut              <= 1'b1;
    end else begin
      xferByte            <= next_xferByte;
      targetByteOffset    <= next_targetByteOffset;
      targetAddr          <= next_targetAddr;
      shortProtocolSelect <= next_shortProtocolSelect;
      fastClockTest       <= next_fastClockTest;
      requestError        <= next_requestError;
      divCnt              <= next_divCnt;
      txn                 <= next_txn;
      cmdValid            <= next_cmdValid;
      cmd                 <= next_cmd;
      txByte              <= next_txByte;
      ackOut              <= next_ackOut;
    end
  end

  // Read data
  always_comb begin
    regRdata = 8'h00;
    if (regRead) begin
      if (hit(regAddr, `SBA_OFF_DATA))   regRdata = xferByte;
      if (hit(regAddr, `SBA_OFF_INDEX))  regRdata = targetByteOffset;
      if (hit(regAddr, `SBA_OFF_TARGET)) regRdata = targetAddr;
      if (hit(regAddr, `SBA_OFF_CTRL)) begin
        regRdata[`SBA_BIT_PROT] = shortProtocolSelect;
        regRdata[`SBA_BIT_BUSY] = requestInProgress;
        regRdata[`SBA_BIT_TEST] = fastClockTest;
        regRdata[`SBA_BIT_ERR]  = requestError;
      end
    end
  end

  sba_bit_engine u_bit (
    .clk      (clk),
    .reset    (reset),
    .tick     (tick),
    .cmdValid (cmdValid),
    .cmd      (cmd),
    .txByte   (txByte),
    .ackOut   (ackOut),
    .cmdDone  (cmdDone),
    .rxByte   (rxByte),
    .nackSeen (nackSeen),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sclOutEn (sclOutEn),
    .sdaOutEn (sdaOutEn)
  );
endmodule
`default_nettype wire

/* sba_params.svh */
// Constants for the serial bus byte access engine.
// Assumes inclusion by sba_pkg.sv and the design modules only.
`ifndef SBA_PARAMS_SVH
`define SBA_PARAMS_SVH
`define SBA_OFF_DATA     8'hB0
`define SBA_OFF_INDEX    8'hB1
`define SBA_OFF_TARGET   8'hB2
`define SBA_OFF_CTRL     8'hB3
`define SBA_RST_BYTE     8'h00
`define SBA_BIT_PROT     7
`define SBA_BIT_BUSY     5
`define SBA_BIT_TEST     2
`define SBA_BIT_ERR      1
`define SBA_CLK_MHZ      125
`define SBA_SCL_KHZ      100
`define SBA_SCL_TEST_KHZ 1000
`endif

/* sba_pkg.sv */
// Types for the serial bus byte access engine.
// Assumes sba_params.svh is on the include path.
package sba_pkg;
  // Bit-level engine states
  typedef enum logic [3:0] {
    SBA_B_IDLE  = 4'b0001,
    SBA_B_START = 4'b0010,
    SBA_B_BIT   = 4'b0100,
    SBA_B_STOP  = 4'b1000
  } sba_bit_t;
  // Bit engine commands
  typedef enum logic [1:0] {
    SBA_CMD_START = 2'h0,
    SBA_CMD_BYTE  = 2'h1,
    SBA_CMD_STOP  = 2'h2
  } sba_cmd_t;
  // Transaction states
  typedef enum logic [7:0] {
    SBA_T_IDLE  = 8'b00000001,
    SBA_T_ADDR  = 8'b00000010,
    SBA_T_INDEX = 8'b00000100,
    SBA_T_RSTA  = 8'b00001000,
    SBA_T_RADDR = 8'b00010000,
    SBA_T_DATA  = 8'b00100000,
    SBA_T_STOP  = 8'b01000000,
    SBA_T_DONE  = 8'b10000000
  } sba_txn_t;
endpackage

/* sba_bit_engine.sv */
// Bit engine: start, stop and one byte with acknowledge on the two-wire bus.
// Assumes a one-cycle quarter-bit tick from the parent; pins sampled here.
`include "sba_params.svh"
`timescale 1ns/10ps
`default_nettype none
module sba_bit_engine (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              tick,
  // Command side
  input  wire logic              cmdValid,
  input  wire sba_pkg::sba_cmd_t cmd,
  input  wire logic [7:0]        txByte,
  input  wire logic              ackOut,
  output logic                   cmdDone,
  output logic [7:0]             rxByte,
  output logic                   nackSeen,
  // Pins; enable low means the pin is pulled low
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sclOutEn,
  output logic                   sdaOutEn
);
  sba_pkg::sba_bit_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [3:0] bitCnt, next_bitCnt;
  logic [8:0] shift, next_shift;
  logic       sclHigh, next_sclHigh, sdaHigh, next_sdaHigh;
  logic       sclMeta, sclSync, sdaMeta, sdaSync;
  logic       done, next_done;
  logic [7:0] rxReg, next_rxReg;
  logic       nack, next_nack;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
    end
  end

  always_comb begin
    next_state   = state;
    next_phase   = phase;
    next_bitCnt  = bitCnt;
    next_shift   = shift;
    next_sclHigh = sclHigh;
    next_sdaHigh = sdaHigh;
    next_done    = 1'b0;
    next_rxReg   = rxReg;
    next_nack    = nack;
    case (state)
      sba_pkg::SBA_B_IDLE: begin
        next_phase = 2'h0;
        if (cmdValid) begin
          next_bitCnt = 4'h0;
          next_shift  = {txByte, ackOut};
          case (cmd)
            sba_pkg::SBA_CMD_START: next_state = sba_pkg::SBA_B_START;
            sba_pkg::SBA_CMD_BYTE:  next_state = sba_pkg::SBA_B_BIT;
            default:                next_state = sba_pkg::SBA_B_STOP;
          endcase
        end
      end
      sba_pkg::SBA_B_START: if (tick) begin
        next_phase = phase + 2'h1;
        case (phase)
          2'h0: next_sdaHigh = 1'b1;
          2'h1: next_sclHigh = 1'b1;
          2'h2: next_sdaHigh = 1'b0;
          default: begin
            next_sclHigh = 1'b0;
            next_done    = 1'b1;
            next_state   = sba_pkg::SBA_B_IDLE;
          end
        endcase
      end
      sba_pkg::SBA_B_BIT: if (tick) begin
        // Hold the phase while the target stretches the clock
        if (!(phase == 2'h2 && !sclSync)) begin
          next_phase = phase + 2'h1;
        end
        case (phase)
          2'h0: next_sdaHigh = shift[8];
          2'h1: next_sclHigh = 1'b1;
          2'h2: if (sclSync) begin
            next_shift = {shift[7:0], sdaSync};
          end
          default: begin
            next_sclHigh = 1'b0;
            next_bitCnt  = bitCnt + 4'h1;
            if (bitCnt == 4'h8) begin
              next_rxReg = shift[8:1];
              next_nack  = shift[0];
              next_done  = 1'b1;
              next_state = sba_pkg::SBA_B_IDLE;
            end
          end
        endcase
      end
      sba_pkg::SBA_B_STOP: if (tick) begin
        next_phase = phase + 2'h1;
        case (phase)
          2'h0: next_sdaHigh = 1'b0;
          2'h1: next_sclHigh = 1'b1;
          2'h2: next_sdaHigh = 1'b1;
          default: begin
            next_done  = 1'b1;
            next_state = sba_pkg::SBA_B_IDLE;
          end
        endcase
      end
      default: next_state = sba_pkg::SBA_B_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state   <= sba_pkg::SBA_B_IDLE;
      phase   <= 2'h0;
      bitCnt  <= 4'h0;
      shift   <= 9'h1FF;
      sclHigh <= 1'b1;
      sdaHigh <= 1'b1;
      done    <= 1'b0;
      rxReg   <= 8'h00;
      nack    <= 1'b0;
    end else begin
      state   <= next_state;
      phase   <= next_phase;
      bitCnt  <= next_bitCnt;
      shift   <= next_shift;
      sclHigh <= next_sclHigh;
      sdaHigh <= next_sdaHigh;
      done    <= next_done;
      rxReg   <= next_rxReg;
      nack    <= next_nack;
    end
  end

  assign sclOutEn = sclHigh;
  assign sdaOutEn = sdaHigh;
  assign cmdDone  = done;
  assign rxByte   = rxReg;
  assign nackSeen = nack;
endmodule
`default_nettype wire

/* sba_serial_byte_access_props.sv */
// Checker for the serial bus byte access engine.
// Assumes it is bound to sba_serial_byte_access and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module sba_serial_byte_access_props #(
  parameter int CLK_MHZ      = 125,
  parameter int SCL_KHZ      = 100,
  parameter int SCL_TEST_KHZ = 1000
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Register port
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // Two-wire bus
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sclOutEn,
  input wire logic       sdaOutEn
);
  localparam int DIV  = CLK_MHZ * 1000 / (SCL_KHZ * 4);
  localparam int DIVF = CLK_MHZ * 1000 / (SCL_TEST_KHZ * 4);
  logic        inTxn, next_inTxn, fast, next_fast, sclQ, sdaQ, stopSeen;
  logic [15:0] gap, next_gap;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_comb begin
    stopSeen   = sclOutEn && sclQ && sdaOutEn && !sdaQ;
    next_inTxn = (inTxn || (regWrite && regAddr == 8'hB2)) && !stopSeen;
    next_fast  = (regWrite && regAddr == 8'hB3) ? regWdata[2] : fast;
    next_gap   = (sclOutEn != sclQ) ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inTxn <= 1'b0;
      fast  <= 1'b0;
      sclQ  <= 1'b1;
      sdaQ  <= 1'b1;
      gap   <= 16'h0000;
    end else begin
      inTxn <= next_inTxn;
      fast  <= next_fast;
      sclQ  <= sclOutEn;
      sdaQ  <= sdaOutEn;
      gap   <= next_gap;
    end
  end
  sequence s_launch;
    regWrite && regAddr == 8'hB2 && !inTxn;
  endsequence
  sequence s_data_write;
    regWrite && regAddr == 8'hB0 && !inTxn;
  endsequence
  sequence s_err_clear;
    regWrite && regAddr == 8'hB3 && regWdata[1] && !inTxn;
  endsequence
  property p_launch_start;
    s_launch |-> ##[1:300] !sdaOutEn;
  endproperty
  property p_idle_quiet;
    !inTxn |-> sclOutEn && sdaOutEn;
  endproperty
  property p_busy_set;
    s_launch ##2 (regRead && regAddr == 8'hB3) |-> regRdata[5];
  endproperty
  property p_ctrl_rsvd;
    (regRead && regAddr == 8'hB3) |-> (regRdata & 8'h59) == 8'h00;
  endproperty
  property p_scl_rate;
    (sclOutEn != sclQ) |-> gap >= (fast ? DIVF : DIV) - 2;
  endproperty
  property p_stop_idle;
    stopSeen |=> (sclOutEn && sdaOutEn) [*4];
  endproperty
  property p_data_back;
    s_data_write ##2 (regRead && regAddr == 8'hB0) |-> regRdata == $past(regWdata, 2);
  endproperty
  property p_target_back;
    s_launch ##2 (regRead && regAddr == 8'hB2) |-> regRdata == $past(regWdata, 2);
  endproperty
  property p_err_clear;
    s_err_clear ##2 (regRead && regAddr == 8'hB3) |-> !regRdata[1];
  endproperty
  a_launch_start: assert property (p_launch_start) else $error("no start after launch");
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus pulled while idle");
  a_busy_set: assert property (p_busy_set) else $error("busy flag not set");
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits not zero");
  a_scl_rate: assert property (p_scl_rate) else $error("serial clock too fast");
  a_stop_idle: assert property (p_stop_idle) else $error("bus busy after stop");
  a_data_back: assert property (p_data_back) else $error("data byte readback");
  a_target_back: assert property (p_target_back) else $error("target readback");
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");
endmodule
bind sba_serial_byte_access sba_serial_byte_access_props #(
  .CLK_MHZ(CLK_MHZ), .SCL_KHZ(SCL_KHZ), .SCL_TEST_KHZ(SCL_TEST_KHZ)
) u_sba_serial_byte_access_props (
  .clk(clk), .reset(reset), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .sclIn(sclIn),
  .sdaIn(sdaIn), .sclOutEn(sclOutEn), .sdaOutEn(sdaOutEn)
);
`default_nettype wire

/* sba_target_model.sv */
// Behavioural two-wire target with a byte memory and a log of bytes seen.
// Assumes wired-AND wires with pull-ups; it never stretches the clock.
`timescale 1ns/10ps
`default_nettype none
module sba_target_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  // Bus wires
  input  wire logic scl,
  input  wire logic sda,
  // Data pull, low pulls the wire low
  output logic      sdaEn
);
  logic [7:0] mem [256];
  logic [7:0] log [$];
  logic [7:0] sr, ptr;
  logic       rd, tx, ack;
  int         cnt, nb;
  initial begin
    sdaEn = 1'b1;
    nb = -1;
    cnt = 0;
    tx = 1'b0;
    rd = 1'b0;
    ack = 1'b0;
    ptr = 8'h00;
  end
  always @(negedge sda) if (scl) begin
    cnt = 0;
    nb = 0;
    tx = 1'b0;
  end
  always @(posedge sda) if (scl) nb = -1;
  always @(posedge scl) if (nb >= 0) begin
    if (cnt < 8) sr = {sr[6:0], sda};
    else ack = !sda;
    cnt++;
  end
  always @(negedge scl) if (nb >= 0) begin
    if (cnt == 8 && !tx) begin
      log.push_back(sr);
      if (nb == 0) rd = sr[0];
      if (nb == 1 && !rd) ptr = sr;
      if (nb == 2 && !rd) mem[ptr] = sr;
      sdaEn = nb == 0 && sr[7:1] != DEV;
    end else if (cnt == 9) begin
      cnt = 0;
      nb++;
      tx = rd && ack;
      if (tx) begin
        sr = mem[ptr];
        ptr++;
      end
      sdaEn = !tx || sr[7];
    end else if (tx && cnt < 8) sdaEn = sr[7];
    else sdaEn = 1'b1;
  end
endmodule
`default_nettype wire

/* sba_serial_byte_access_test.sv */
// Self-checking bench for the serial bus byte access engine.
// Assumes the target model on the wires and a shortened serial clock divider.
`timescale 1ns/10ps
`default_nettype none
module sba_serial_byte_access_test;
  localparam logic [6:0] DEV = 7'h50;
  logic       clk, reset, regWrite, regRead, sclOutEn, sdaOutEn, sdaEn;
  logic [7:0] regAddr, regWdata, regRdata, v;
  int         num_errors, checked;
  wire        sclW = sclOutEn;
  wire        sdaW = sdaOutEn & sdaEn;
  sba_serial_byte_access #(.SCL_KHZ(1000), .SCL_TEST_KHZ(5000)) u_sba_serial_byte_access (
    .clk(clk), .reset(reset), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sclIn(sclW), .sdaIn(sdaW),
    .sclOutEn(sclOutEn), .sdaOutEn(sdaOutEn));
  sba_target_model #(.DEV(DEV)) u_sba_target_model (.scl(sclW), .sda(sdaW), .sdaEn(sdaEn));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(negedge clk);
    v = regRdata;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic poll;
    for (int i = 0; i < 3000; i++) begin
      rd(8'hB3);
      if (v[5] === 1'b0) return;
    end
    num_errors++;
    $display("MISMATCH busyTimeout expected 0 seen 1");
    end_of_test;
  endtask
  task automatic chkLog(input logic [7:0] e [$]);
    chk("byteCount", 8'(u_sba_target_model.log.size()), 8'(e.size()));
    foreach (e[i]) chk("busByte", u_sba_target_model.log[i], e[i]);
    u_sba_target_model.log.delete();
  endtask
  task automatic t_reset;
    logic [7:0] a [5] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4};
    foreach (a[i]) begin
      rd(a[i]);
      chk("resetValue", v, 8'h00);
    end
    wr(8'hB0, 8'h96);
    rd(8'hB0);
    chk("dataReadback", v, 8'h96);
    wr(8'hB1, 8'h69);
    rd(8'hB1);
    chk("offsetReadback", v, 8'h69);
  endtask
  task automatic t_write;
    wr(8'hB0, 8'hA5);
    wr(8'hB1, 8'h3C);
    wr(8'hB2, {DEV, 1'b0});
    rd(8'hB3);
    chk("busyAfterLaunch", v & 8'h20, 8'h20);
    poll;
    chkLog('{8'hA0, 8'h3C, 8'hA5});
    chk("targetMemory", u_sba_target_model.mem[8'h3C], 8'hA5);
    rd(8'hB3);
    chk("statusAfterWrite", v, 8'h00);
  endtask
  task automatic t_read;
    wr(8'hB1, 8'h3C);
    wr(8'hB2, {DEV, 1'b1});
    rd(8'hB2);
    chk("targetReg", v, {DEV, 1'b1});
    wr(8'hB0, 8'hFF);
    poll;
    rd(8'hB0);
    chk("readData", v, 8'hA5);
    chkLog('{8'hA0, 8'h3C, 8'hA1});
  endtask
  task automatic t_nack;
    wr(8'hB2, {7'h11, 1'b0});
    poll;
    rd(8'hB3);
    chk("errorSet", v, 8'h02);
    chkLog('{8'h22});
    wr(8'hB3, 8'h02);
    rd(8'hB3);
    chk("errorCleared", v, 8'h00);
  endtask
  task automatic t_short;
    u_sba_target_model.mem[8'h5A] = 8'hC3;
    wr(8'hB3, 8'h84);
    wr(8'hB0, 8'h5A);
    wr(8'hB2, {DEV, 1'b0});
    poll;
    chkLog('{8'hA0, 8'h5A});
    wr(8'hB2, {DEV, 1'b1});
    poll;
    rd(8'hB0);
    chk("shortReadData", v, 8'hC3);
    chkLog('{8'hA1});
    wr(8'hB3, 8'h00);
  endtask
  initial begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    num_errors = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_write;
    t_read;
    t_nack;
    t_short;
    end_of_test;
  end
endmodule
`default_nettype wire
